// ==== rtl/ext_bus_ctl_regs.vh ====
/*
 holds: constants for the external bus control block.
 assumes: included by rtl/ext_bus_ctl.v only.
*/
`ifndef EXT_BUS_CTL_REGS_VH
`define EXT_BUS_CTL_REGS_VH
// bit of the window selection value that enables bus hold
`define HOLD_EN_BIT 7
`define WSR_RESET 8'h00
// state codes of the bus sequencer
`define ST_IDLE 3'h0
`define ST_WAIT 3'h1
`define ST_DONE 3'h2
`define ST_HOLD 3'h3
// width of the wait state counter
`define WAIT_W 2
`endif

// ==== rtl/ext_bus_ctl.v ====
/*
 holds: external bus control sequencer for the hold handshake, the
 fetch indicator, the read strobe and ready driven wait states.
 assumes: the core side inputs are synchronous to mclk, are steady
 while cyc_req is high, and a request stays high until cyc_done;
 hold_req_n and ready come straight from pins and are synchronised
 here; wsr, hold_pin_sf and wait_states come from core registers
 and change only between cycles; bus_drive_en is the output enable
 of the address, data and strobe pad drivers; the outside master
 watches bus_released_ack_n before it drives the bus itself, and
 a memory that needs more time pulls ready low early enough for
 the two synchroniser cycles.
*/

`timescale 1ns/10ps
`include "ext_bus_ctl_regs.vh"
module ext_bus_ctl #(
   parameter WAIT_W = `WAIT_W
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // configuration from the core
   input wire [7:0] wsr,
   input wire hold_pin_sf,
   input wire [WAIT_W-1:0] wait_states,
   // access request from the core
   input wire cyc_req,
   input wire cyc_ext,
   input wire cyc_read,
   input wire cyc_fetch,
   output wire cyc_done,
   // pins
   input wire hold_req_n,
   input wire ready,
   output reg bus_released_ack_n,
   output reg pending_cycle_req_n,
   output reg fetch_indicator,
   output reg rd_n,
   output reg bus_drive_en
);

   // state codes of the bus sequencer
   localparam ST_IDLE = 3'b000;
   localparam ST_WAIT = 3'b001;
   localparam ST_DONE = 3'b010;
   localparam ST_HOLD = 3'b011;
   // end point and decrement step of the wait state counter
   localparam [WAIT_W-1:0] WAIT_ZERO = {WAIT_W{1'b0}};
   localparam [WAIT_W-1:0] WAIT_ONE = {{(WAIT_W-1){1'b0}}, 1'b1};
   // synchronised pins: bit 0 takeover request, bit 1 ready
   localparam SYNC_W = 2;
   localparam [SYNC_W-1:0] SYNC_RST = 2'b10;

   // the sequencer has let go of the bus
   function in_hold;
      input [2:0] st;
      begin
         in_hold = (st == ST_HOLD);
      end
   endfunction

   // the sequencer is inside a running bus cycle
   function in_cycle;
      input [2:0] st;
      begin
         in_cycle = (st == ST_WAIT) || (st == ST_DONE);
      end
   endfunction

   // a cycle attribute that only shows on the pins for external cycles
   function ext_qual;
      input ext;
      input attr;
      begin
         ext_qual = ext & attr;
      end
   endfunction

   // synchroniser outputs and qualifiers
   wire [SYNC_W-1:0] pin_raw;
   wire [SYNC_W-1:0] pin_sync;
   wire hold_sync;
   wire rdy_sync;
   wire hold_en;
   wire hold_want;
   wire take;
   wire count_end;
   wire cycle_end;

   // sequencer state and counter
   reg [2:0] state;
   reg [2:0] next_state;
   reg [WAIT_W-1:0] wcnt;
   reg [WAIT_W-1:0] next_wcnt;

   // captured cycle attributes
   reg ext_cur;
   reg rd_cur;
   reg fetch_cur;

   // next values of the pin outputs
   reg next_pend_n;
   reg next_fetch;
   reg next_rd_n;
   genvar gi;

   // pin inputs pass two flops before any logic reads them
   assign pin_raw = {ready, ~hold_req_n};
   generate
      for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
         reg s1;
         reg s2;
         always @(posedge mclk) begin
            if (!rst_n) begin
               s1 <= SYNC_RST[gi];
               s2 <= SYNC_RST[gi];
            end else begin
               s1 <= pin_raw[gi];
               s2 <= s1;
            end
         end
         assign pin_sync[gi] = s2;
      end
   endgenerate
   assign hold_sync = pin_sync[0];
   // ready costs two cycles through the flops, so a slow part must
   // pull it low before the last programmed wait state is spent
   assign rdy_sync = pin_sync[1];

   // takeover request qualification
   assign hold_en = wsr[`HOLD_EN_BIT];
   assign hold_want = hold_sync & hold_en & hold_pin_sf;

   // hold wins over a new request so the bus is not taken back at once
   assign take = (state == ST_IDLE) && !hold_want && cyc_req;
   assign count_end = (wcnt == WAIT_ZERO);
   assign cycle_end = count_end && (!ext_cur || rdy_sync);
   assign cyc_done = (state == ST_DONE);

   // next state of the sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (hold_want) begin
               next_state = ST_HOLD;
            end else if (cyc_req) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cycle_end) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // a hold seen mid cycle is granted once the cycle has ended
            if (hold_want) begin
               next_state = ST_HOLD;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_HOLD: begin
            // clearing the enable bit also ends the hold
            if (!hold_want) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // internal cycles carry no programmed wait states
   always @* begin
      next_wcnt = wcnt;
      if (take) begin
         if (cyc_ext) begin
            next_wcnt = wait_states;
         end else begin
            next_wcnt = WAIT_ZERO;
         end
      end else if (state == ST_WAIT && !count_end) begin
         next_wcnt = wcnt - WAIT_ONE;
      end
   end

   // sequencer and wait counter registers
   always @(posedge mclk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         wcnt <= WAIT_ZERO;
      end else begin
         state <= next_state;
         wcnt <= next_wcnt;
      end
   end

   // attributes of the running cycle, captured when it is taken
   always @(posedge mclk) begin
      if (!rst_n) begin
         ext_cur <= 1'b0;
         rd_cur <= 1'b0;
         fetch_cur <= 1'b0;
      end else if (take) begin
         ext_cur <= cyc_ext;
         rd_cur <= cyc_read;
         fetch_cur <= cyc_fetch;
      end
   end

   // outputs follow the next state so they line up with the cycle
   always @(posedge mclk) begin
      if (!rst_n) begin
         bus_released_ack_n <= 1'b1;
      end else begin
         bus_released_ack_n <= ~in_hold(next_state);
      end
   end

   // address, data and strobe drivers float for the whole hold
   always @(posedge mclk) begin
      if (!rst_n) begin
         bus_drive_en <= 1'b1;
      end else begin
         bus_drive_en <= ~in_hold(next_state);
      end
   end

   // once raised it stays until the sequencer leaves the hold state
   always @* begin
      next_pend_n = pending_cycle_req_n;
      if (!in_hold(next_state)) begin
         next_pend_n = 1'b1;
      end else if (cyc_req && cyc_ext) begin
         next_pend_n = 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         pending_cycle_req_n <= 1'b1;
      end else begin
         pending_cycle_req_n <= next_pend_n;
      end
   end

   // fetch indicator stands from the taking edge to the cycle's end
   always @* begin
      if (take) begin
         next_fetch = ext_qual(cyc_ext, cyc_fetch);
      end else if (in_cycle(next_state)) begin
         next_fetch = ext_qual(ext_cur, fetch_cur);
      end else begin
         next_fetch = 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         fetch_indicator <= 1'b0;
      end else begin
         fetch_indicator <= next_fetch;
      end
   end

   // read strobe for external reads only
   always @* begin
      if (take) begin
         next_rd_n = ~ext_qual(cyc_ext, cyc_read);
      end else if (in_cycle(next_state)) begin
         next_rd_n = ~ext_qual(ext_cur, rd_cur);
      end else begin
         next_rd_n = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         rd_n <= 1'b1;
      end else begin
         rd_n <= next_rd_n;
      end
   end

endmodule

// ==== verif/ext_far_model.sv ====
/* far side: slow memory on ready, outside master on takeover pin */
`timescale 1ns/10ps
module ext_far_model(input wire mclk, rd_n, slow, want_bus,
output reg ready = 1'b1, output wire hold_req_n);
// a slow part holds ready low until it sees its read strobe
always @(posedge mclk) ready <= !slow || !rd_n;
assign hold_req_n = !want_bus;
endmodule

// ==== verif/ext_bus_ctl_checker.sv ====
/* port checker, bound into ext_bus_ctl */
`timescale 1ns/10ps
module ext_bus_ctl_checker(input wire mclk, rst_n, cyc_done, hold_req_n,
bus_released_ack_n, pending_cycle_req_n, fetch_indicator, rd_n,
bus_drive_en, hold_pin_sf, input wire [7:0] wsr);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
hold_en_a: assert property (!bus_released_ack_n |->
$past(wsr[7] & hold_pin_sf)) else $error("hold off");
ack_lat_a: assert property (!bus_released_ack_n |->
!$past(hold_req_n, 3)) else $error("ack");
bus_float_a: assert property (!bus_released_ack_n |->
!bus_drive_en) else $error("float");
rd_hold_a: assert property (!rd_n && !cyc_done |=> !rd_n)
else $error("rd");
fi_hold_a: assert property (fetch_indicator && !cyc_done |=>
fetch_indicator) else $error("fetch");
fi_read_a: assert property (fetch_indicator |-> !rd_n)
else $error("fetch rd");
cyc_end_a: assert property (cyc_done |=> rd_n && !fetch_indicator)
else $error("end");
pend_ack_a: assert property ($fell(pending_cycle_req_n) |->
!bus_released_ack_n) else $error("pend");
cover property (!rd_n);
cover property (fetch_indicator);
cover property (!pending_cycle_req_n);
endmodule
bind ext_bus_ctl ext_bus_ctl_checker i_chk(.*);

// ==== verif/ext_bus_ctl_tb.sv ====
/* bench for ext_bus_ctl; far side in ext_far_model */
`timescale 1ns/10ps
module ext_bus_ctl_tb;
reg mclk = 0, rst_n = 0, cyc_req = 0, cyc_ext = 0, cyc_read = 0;
reg cyc_fetch = 0, slow = 0, want = 0, hold_pin_sf = 0;
reg [7:0] wsr = 8'h80, n;
reg [1:0] wait_states = 2'h2;
wire cyc_done, hold_req_n, ready, bus_released_ack_n, pending_cycle_req_n;
wire fetch_indicator, rd_n, bus_drive_en;
integer errors = 0, checks_done = 0;
ext_bus_ctl i_ext_bus_ctl(.*);
ext_far_model i_ext_far_model(.*, .want_bus(want));
always #50 mclk = !mclk;
task chk(input [7:0] seen, exp); begin
   checks_done = checks_done + 1;
   if (seen !== exp) errors = errors + 1;
   if (seen !== exp) $display("CHECK FAILED %0t got %0d", $time, seen);
end endtask
task conclude; begin
   $display("%0d checks, %0d errors", checks_done, errors);
   if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
   else $display("SIMULATION FAILED");
   $finish;
end endtask
// lat 0 means stretched by ready: only a lower bound is known
task cyc(input e, r, f, input [7:0] lat); begin
   @(negedge mclk) {cyc_req, cyc_ext, cyc_read, cyc_fetch} = {1'b1, e, r, f};
   @(negedge mclk) chk(!rd_n, e & r);
   chk(fetch_indicator, e & f);
   for (n = 0; !cyc_done && n < 20; n = n + 1) @(negedge mclk);
   cyc_req = 0;
   chk(lat ? n : n > wait_states + 1 && n < 20, lat ? lat : 1);
   if (n == 20) conclude;
end endtask
task t_bus; begin
   cyc(1, 1, 1, 3);
   cyc(1, 1, 0, 3);
   cyc(1, 0, 0, 3);
   cyc(0, 1, 1, 1);
   slow = 1;
   cyc(0, 1, 0, 1);
   wait_states = 2'h0;
   cyc(1, 1, 0, 0);
   slow = 0;
   $display("bus cycles done");
end endtask
task t_hold; begin
   want = 1;
   repeat (5) @(negedge mclk);
   chk(bus_released_ack_n, 1);
   hold_pin_sf = 1;
   repeat (2) @(negedge mclk);
   chk({bus_released_ack_n, bus_drive_en}, 0);
   {cyc_req, cyc_ext, cyc_read} = 3'h7;
   @(negedge mclk) chk(pending_cycle_req_n, 0);
   want = 0;
   for (n = 0; !cyc_done && n < 20; n = n + 1) @(negedge mclk);
   cyc_req = 0;
   chk(n > 2 && n < 20, 1);
   $display("hold done");
end endtask
initial begin
   repeat (2) @(negedge mclk);
   rst_n = 1;
   t_bus;
   t_hold;
   conclude;
end
endmodule
